// ===== bench/dispatch_decoder_props.sv
// port-level checks for the dispatch decoder
module dispatch_decoder_props (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic [1:0]            in_valid,
  input wire logic [1:0][7:0]       in_opcode,
  input wire logic [1:0][7:0]       in_second,
  input wire logic                  sched_ready,
  input wire logic [1:0]            advance_r,
  input wire logic [1:0]            dec_valid_r,
  input wire logic [1:0][1:0]       dec_type_r,
  input wire logic [1:0][2:0][3:0]  op_kind_r,
  input wire logic [1:0][2:0][2:0]  op_unit_r,
  input wire logic [1:0][2:0]       reg_operand_r,
  input wire logic [1:0]            mem_form_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic       take;    // fetch group accepted at this edge
  logic       bad;     // some op sits on a unit its kind forbids
  logic [7:0] modrm_q; // slot 0 second byte of the last cycle
  assign take = in_valid[0] && (sched_ready || dec_valid_r == 2'b00);
  // keep the byte so the answer can be tied to its cause
  always_ff @(posedge mclk) begin
    modrm_q <= in_second[0];
  end
  // kind to unit table over every slot and op
  always_comb begin
    bad = 1'b0;
    for (int s = 0; s < 2; s++) begin
      for (int o = 0; o < 3; o++) begin
        case (op_kind_r[s][o])
          4'h1, 4'h9, 4'ha: bad |= op_unit_r[s][o] != 3'h1;
          4'h2: bad |= op_unit_r[s][o] != 3'h2;
          4'h3: bad |= op_unit_r[s][o] != 3'h3 && op_unit_r[s][o] != 3'h4;
          4'h4: bad |= op_unit_r[s][o] != 3'h3;
          4'h5: bad |= op_unit_r[s][o] != 3'h5;
          4'h6: bad |= op_unit_r[s][o] != 3'h6;
          4'h7: bad |= op_unit_r[s][o] != 3'h7;
          default: bad |= op_unit_r[s][o] != 3'h0; // none and limm
        endcase
      end
    end
  end
  a_adv_legal: assert property (advance_r != 2'b11)
    else $error("advance count out of range");
  a_pair_short: assert property (advance_r == 2'b10 |->
    dec_type_r == 4'h5 && dec_valid_r == 2'b11)
    else $error("paired group not two short decodes");
  a_long_alone: assert property (dec_valid_r[0] &&
    dec_type_r[0] != 2'h1 |-> !dec_valid_r[1])
    else $error("second slot beside a long or vector decode");
  a_held_stall: assert property (dec_valid_r != 2'b00 &&
    !sched_ready |=> advance_r == 2'b00 && $stable(dec_type_r) &&
    $stable(op_kind_r))
    else $error("group changed while scheduler stalled");
  a_unit_map: assert property (!bad)
    else $error("operation steered to a wrong unit");
  a_mem_form: assert property (take && in_opcode[0] == 8'h01 |=>
    mem_form_r[0] == (modrm_q[7:6] != 2'b11))
    else $error("memory form does not follow mod field");
  a_reg_field: assert property (take && in_opcode[0] == 8'h01 |=>
    reg_operand_r[0] == modrm_q[5:3])
    else $error("register operand not from reg field");
  a_adc_mem: assert property (take && in_opcode[0] == 8'h83 &&
    in_second[0][5:3] == 3'h2 && in_second[0][7:6] != 2'b11 |=>
    dec_type_r[0] == 2'h2 && op_kind_r[0] == 12'h241)
    else $error("memory add with carry not load op store");
endmodule

// ===== bench/sched_model.sv
// scheduler stand-in that accepts decoded groups or stalls on demand
module sched_model (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic stall,
  output logic      sched_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready is registered, so a stall request takes hold one edge late
  always_ff @(posedge mclk) begin
    sched_ready <= resetn && !stall;
  end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the dispatch decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 mclk, resetn, op_size32, addr_size32;
  logic                 stall, sched_ready;
  logic [1:0]           in_valid, advance_r, dec_valid_r;
  logic [1:0]           mem_form_r, vector_form_r;
  logic [1:0][7:0]      in_opcode, in_second, in_third;
  logic [1:0][1:0]      dec_type_r;
  logic [1:0][2:0][3:0] op_kind_r;
  logic [1:0][2:0][2:0] op_unit_r;
  logic [1:0][2:0]      op_chain_r, reg_operand_r, rm_operand_r;
  logic [1:0][3:0]      length_r;
  int                   errors, n_compared;
  dispatch_decoder dut (.mclk, .resetn, .in_valid, .in_opcode, .in_second,
    .in_third, .op_size32, .addr_size32, .sched_ready, .advance_r,
    .dec_valid_r, .dec_type_r, .op_kind_r, .op_unit_r, .op_chain_r,
    .reg_operand_r, .rm_operand_r, .mem_form_r, .vector_form_r,
    .length_r);
  sched_model sched (.mclk, .resetn, .stall, .sched_ready);
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // present a window for one cycle; the decoder must be free to take it
  task automatic issue(input logic [1:0] v, input logic [7:0] a0, b0, c0,
                       a1, b1, c1);
    @(posedge mclk);
    in_valid  <= v;
    in_opcode <= {a1, a0};
    in_second <= {b1, b0};
    in_third  <= {c1, c0};
    @(posedge mclk);
    in_valid  <= 2'b00;
    #1;
  endtask
  // two short forms pair; steering starts at unit x after reset
  task automatic t_pair();
    issue(2'b11, 8'h11, 8'hd3, 8'h00, 8'h01, 8'hc8, 8'h00);
    chk("advance", advance_r, 2'h2);
    chk("types", dec_type_r, 4'h5);
    chk("units", {op_unit_r[1][0], op_unit_r[0][0]}, 6'h23);
    chk("reg", reg_operand_r[0], 3'h2);
    chk("rm", rm_operand_r[0], 3'h3);
    for (int o = 0; o < 2; o++) begin
      op_size32 <= o[0];
      issue(2'b11, 8'h83, 8'hd1, 8'h00, 8'hb8, 8'h00, 8'h00);
      chk("adc kind", op_kind_r[0], 12'h004);
      chk("adc unit", op_unit_r[0], 9'h003);
      chk("limm", {op_kind_r[1], op_unit_r[1]}, 21'h001000);
      chk("len", length_r, o[0] ? 8'h53 : 8'h33);
    end
    $display("t_pair done");
  endtask
  // memory destination: long, alone, length by mod field
  task automatic t_mem();
    logic [3:0] len [3];
    len = '{4'h3, 4'h4, 4'h7};
    addr_size32 <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      issue(2'b11, 8'h83, {m[1:0], 6'h10}, 8'h00, 8'h01, 8'hc0, 8'h00);
      chk("advance", advance_r, 2'h1);
      chk("valid", dec_valid_r, 2'h1);
      chk("kinds", op_kind_r[0], 12'h241);
      chk("units", op_unit_r[0], 9'h099);
      chk("mem", mem_form_r[0], 1'b1);
      chk("len", length_r[0], len[m]);
    end
    $display("t_mem done");
  endtask
  // adjust and the three vector extension exceptions
  task automatic t_vec();
    logic [17:0] tbl [4];
    tbl = '{{8'h37, 8'h00, 2'h3}, {8'h0f, 8'h77, 2'h3},
            {8'h0f, 8'h0e, 2'h3}, {8'h0f, 8'h0d, 2'h2}};
    for (int i = 0; i < 4; i++) begin
      issue(2'b11, tbl[i][17:10], tbl[i][9:2], 8'h00,
            8'h01, 8'hc0, 8'h00);
      chk("vtype", dec_type_r[0], tbl[i][1:0]);
      chk("advance", advance_r, 2'h1);
    end
    $display("t_vec done");
  endtask
  // multimedia, branch and float steering
  task automatic t_units();
    issue(2'b11, 8'h0f, 8'hfe, 8'hd1, 8'h74, 8'h05, 8'h00);
    chk("types", dec_type_r, 4'h5);
    chk("meu", {op_kind_r[0][0], op_unit_r[0][0]}, 7'h3f);
    chk("operands", {reg_operand_r[0], rm_operand_r[0]}, 6'h11);
    chk("vform", vector_form_r[0], 1'b1);
    chk("branch", {op_kind_r[1][0], op_unit_r[1][0]}, 7'h2d);
    issue(2'b01, 8'hd8, 8'hc1, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("float", {op_kind_r[0][0], op_unit_r[0][0]}, 7'h36);
    $display("t_units done");
  endtask
  // byte swap and a two-chain exchange
  task automatic t_long();
    issue(2'b01, 8'h0f, 8'hc9, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("bswap", {dec_type_r[0], op_kind_r[0]}, 14'h2003);
    chk("bswap reg", reg_operand_r[0], 3'h1);
    issue(2'b01, 8'h87, 8'hc1, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("chains", op_chain_r[0], 3'h2);
    issue(2'b01, 8'h01, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("add mem", {dec_type_r[0], op_kind_r[0]}, 14'h2231);
    chk("add len", length_r[0], 4'h3);
    $display("t_long done");
  endtask
  // scheduler stall holds the group and refuses new input
  task automatic t_stall();
    @(posedge mclk);
    stall <= 1'b1;
    repeat (2) @(posedge mclk);
    issue(2'b11, 8'h01, 8'hc8, 8'h00, 8'h01, 8'hc8, 8'h00);
    in_valid  <= 2'b01;
    in_opcode <= {8'h00, 8'h37};
    repeat (3) @(posedge mclk);
    #1;
    chk("held adv", advance_r, 2'h0);
    chk("held type", dec_type_r, 4'h5);
    stall <= 1'b0;
    // model ready lands one edge later, the take one edge after that
    repeat (2) @(posedge mclk);
    in_valid <= 2'b00;
    #1;
    chk("resume", {advance_r, dec_type_r[0]}, 4'h7);
    $display("t_stall done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // cuts a hang far beyond the sixty or so cycles the tests take
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  initial begin
    resetn = 1'b0;
    {op_size32, addr_size32, stall} = 3'b000;
    in_valid = 2'b00;
    {in_opcode, in_second, in_third} = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_pair();
    t_mem();
    t_vec();
    t_units();
    t_long();
    t_stall();
    wrap_up();
  end
endmodule
bind dispatch_decoder dispatch_decoder_props props (.mclk, .resetn,
  .in_valid, .in_opcode, .in_second, .sched_ready, .advance_r,
  .dec_valid_r, .dec_type_r, .op_kind_r, .op_unit_r, .reg_operand_r,
  .mem_form_r);

// ===== core/decode_consts.svh
// constants for the dispatch decode classifier
// Contract
// - register operand from modrm bits 5 to 3
// - second vector register from modrm bits 2:0
// - mod 11 register form, else memory form
// - per clock: two short, one long, one vector
// - any two short instructions pair together
// - vector extensions short except three non-short
// - loads to load unit, stores store unit
// - X-restricted operations go only to unit X
// - immediate loads use no execution unit
// - vector, branch, float ops to own units
// - one dependent chain, some emit two chains
// - 83h /2 register form: short, one X op
// - 83h /2 memory form: long load-op-store
// - full immediates 16/32 bits, short ones 8
// - 0Fh C8h-CFh byte swap: long, one op
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH
`define MODRM_MOD_HI     7
`define MODRM_MOD_LO     6
`define MODRM_REG_HI     5
`define MODRM_REG_LO     3
`define MODRM_RM_HI      2
`define MODRM_RM_LO      0
`define MOD_REG_FORM     2'b11
`define MOD_DISP8        2'b01
`define MOD_DISP_FULL    2'b10
`define MOD_NO_DISP      2'b00
`define RM_SIB           3'b100
`define RM_DISP_ONLY_32  3'b101
`define RM_DISP_ONLY_16  3'b110
`define OPC_ESCAPE       8'h0f
`define OPC_GRP_IMM_FULL 8'h81
`define OPC_XCHG         8'h87
`define OPC2_EMMS        8'h77
`define OPC2_FEMMS       8'h0e
`define OPC2_PREFETCH    8'h0d
`define OPC2_PACKED_FLT  8'h0f
`define EXT_ADD          3'b000
`define EXT_ADC          3'b010
`define EXT_AND          3'b100
`define LEN_FULL_32      4'h4
`define LEN_FULL_16      4'h2
`define STEER_RESET      1'b0
`endif

// ===== core/decode_pkg.sv
// types shared by the dispatch decode classifier
package decode_pkg;
  // decode path an instruction takes
  typedef enum logic [1:0] {
    DT_NONE   = 2'b00,
    DT_SHORT  = 2'b01,
    DT_LONG   = 2'b10,
    DT_VECTOR = 2'b11
  } dtype_type;
  // internal operation kinds
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_LOAD   = 4'h1,
    OP_STORE  = 4'h2,
    OP_ALU    = 4'h3,
    OP_ALUX   = 4'h4,
    OP_BRANCH = 4'h5,
    OP_FLOAT  = 4'h6,
    OP_MEU    = 4'h7,
    OP_LIMM   = 4'h8,
    OP_FLOAD  = 4'h9,
    OP_MLOAD  = 4'ha
  } op_kind_type;
  // execution unit targets; none also means control unit only
  typedef enum logic [2:0] {
    UNIT_NONE   = 3'b000,
    UNIT_LOAD   = 3'b001,
    UNIT_STORE  = 3'b010,
    UNIT_INT_X  = 3'b011,
    UNIT_INT_Y  = 3'b100,
    UNIT_BRANCH = 3'b101,
    UNIT_FPU    = 3'b110,
    UNIT_MEU    = 3'b111
  } unit_type;
  // immediate field size class
  typedef enum logic [1:0] {
    IMM_NONE = 2'b00,
    IMM_BYTE = 2'b01,
    IMM_FULL = 2'b10
  } imm_size_type;
endpackage

// ===== core/decode_slot.sv
// single-instruction opcode and modrm classifier
`include "decode_consts.svh"
module decode_slot (
  input  wire logic                          valid,
  input  wire logic [7:0]                    opcode,
  input  wire logic [7:0]                    second,
  input  wire logic [7:0]                    third,
  output decode_pkg::dtype_type              dtype,
  output decode_pkg::op_kind_type [2:0]      op_kind,
  output logic [2:0]                         op_chain,
  output logic                               has_modrm,
  output logic                               escaped,
  output logic                               mem_form,
  output logic                               vector_form,
  output logic [7:0]                         modrm,
  output decode_pkg::imm_size_type           imm_size,
  output logic [2:0]                         reg_operand,
  output logic [2:0]                         rm_operand
);
  logic       mem_raw;     // mod field says memory
  logic       reg_in_opc;  // register coded in the opcode byte
  logic [2:0] ext;         // group extension field

  // modrm follows the last opcode byte
  assign escaped = (opcode == `OPC_ESCAPE);
  assign modrm   = escaped ? third : second;
  assign ext     = modrm[`MODRM_REG_HI:`MODRM_REG_LO];
  assign mem_raw = modrm[`MODRM_MOD_HI:`MODRM_MOD_LO] != `MOD_REG_FORM;
  assign mem_form = has_modrm & mem_raw;
  // opcode-coded register wins, else reg field
  assign reg_operand = !reg_in_opc ? ext :
                       (escaped ? second[2:0] : opcode[2:0]);
  assign rm_operand = modrm[`MODRM_RM_HI:`MODRM_RM_LO];

  // classify; anything unknown takes the vector path
  always_comb begin
    decode_pkg::op_kind_type alu_k;
    alu_k = opcode[0] ? decode_pkg::OP_ALU : decode_pkg::OP_ALUX;
    dtype       = decode_pkg::DT_NONE;
    op_kind[0]  = decode_pkg::OP_NONE;
    op_kind[1]  = decode_pkg::OP_NONE;
    op_kind[2]  = decode_pkg::OP_NONE;
    op_chain    = 3'h0;
    has_modrm   = 1'b0;
    imm_size    = decode_pkg::IMM_NONE;
    reg_in_opc  = 1'b0;
    vector_form = 1'b0;
    if (valid) begin
      dtype = decode_pkg::DT_VECTOR;
      unique case (opcode) inside
        8'h00, 8'h01, 8'h10, 8'h11, 8'h20, 8'h21: begin
          has_modrm = 1'b1;
          if (mem_raw) begin // memory destination
            dtype      = decode_pkg::DT_LONG;
            op_kind[0] = decode_pkg::OP_LOAD;
            op_kind[1] = alu_k;
            op_kind[2] = decode_pkg::OP_STORE;
          end else begin
            dtype      = decode_pkg::DT_SHORT;
            op_kind[0] = alu_k;
          end
        end
        8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h23: begin
          has_modrm = 1'b1;
          dtype     = decode_pkg::DT_SHORT;
          if (mem_raw) begin // memory source
            op_kind[0] = decode_pkg::OP_LOAD;
            op_kind[1] = alu_k;
          end else begin
            op_kind[0] = alu_k;
          end
        end
        8'h04, 8'h05, 8'h14, 8'h15, 8'h24, 8'h25: begin
          dtype      = decode_pkg::DT_SHORT;
          op_kind[0] = alu_k;
          imm_size   = opcode[0] ? decode_pkg::IMM_FULL
                                 : decode_pkg::IMM_BYTE;
        end
        8'h80, 8'h81, 8'h83: begin
          has_modrm = 1'b1;
          imm_size  = (opcode == `OPC_GRP_IMM_FULL) ?
                      decode_pkg::IMM_FULL : decode_pkg::IMM_BYTE;
          // only the add, adc and and extensions are classified
          if (ext inside {`EXT_ADD, `EXT_ADC, `EXT_AND}) begin
            alu_k = (opcode == `OPC_GRP_IMM_FULL) ?
                    decode_pkg::OP_ALU : decode_pkg::OP_ALUX;
            if (mem_raw) begin
              dtype      = decode_pkg::DT_LONG;
              op_kind[0] = decode_pkg::OP_LOAD;
              op_kind[1] = alu_k;
              op_kind[2] = decode_pkg::OP_STORE;
            end else begin
              dtype      = decode_pkg::DT_SHORT;
              op_kind[0] = alu_k;
            end
          end
        end
        8'h37, 8'h3f: dtype = decode_pkg::DT_VECTOR;
        8'hd4, 8'hd5: imm_size = decode_pkg::IMM_BYTE;
        `OPC_XCHG: begin
          has_modrm = 1'b1;
          if (!mem_raw) begin // two independent moves
            dtype      = decode_pkg::DT_LONG;
            op_kind[0] = decode_pkg::OP_ALU;
            op_kind[1] = decode_pkg::OP_ALU;
            op_chain   = 3'b010;
          end
        end
        [8'h70:8'h7f]: begin
          dtype      = decode_pkg::DT_SHORT;
          op_kind[0] = decode_pkg::OP_BRANCH;
          imm_size   = decode_pkg::IMM_BYTE;
        end
        [8'hb0:8'hbf]: begin
          dtype      = decode_pkg::DT_SHORT;
          op_kind[0] = decode_pkg::OP_LIMM;
          reg_in_opc = 1'b1;
          imm_size   = opcode[3] ? decode_pkg::IMM_FULL
                                 : decode_pkg::IMM_BYTE;
        end
        8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf: begin
          has_modrm  = 1'b1;
          dtype      = decode_pkg::DT_SHORT;
          op_kind[0] = mem_raw ? decode_pkg::OP_FLOAD
                               : decode_pkg::OP_FLOAT;
          op_kind[1] = mem_raw ? decode_pkg::OP_FLOAT
                               : decode_pkg::OP_NONE;
        end
        `OPC_ESCAPE: begin
          unique case (second) inside
            `OPC2_EMMS, `OPC2_FEMMS: dtype = decode_pkg::DT_VECTOR;
            `OPC2_PREFETCH: begin
              has_modrm  = 1'b1;
              dtype      = decode_pkg::DT_LONG;
              op_kind[0] = decode_pkg::OP_LOAD;
            end
            [8'hc8:8'hcf]: begin
              dtype      = decode_pkg::DT_LONG;
              op_kind[0] = decode_pkg::OP_ALU;
              reg_in_opc = 1'b1;
            end
            // 77h is left out of the row so the vector exit stays unique
            `OPC2_PACKED_FLT, [8'h60:8'h76], [8'h78:8'h7f],
            [8'hd0:8'hff]: begin
              has_modrm   = 1'b1;
              vector_form = 1'b1;
              dtype       = decode_pkg::DT_SHORT;
              op_kind[0]  = mem_raw ? decode_pkg::OP_MLOAD
                                    : decode_pkg::OP_MEU;
              op_kind[1]  = mem_raw ? decode_pkg::OP_MEU
                                    : decode_pkg::OP_NONE;
              // shift-by-immediate rows and the suffix byte form
              if (second == `OPC2_PACKED_FLT ||
                  second inside {[8'h70:8'h73]})
                imm_size = decode_pkg::IMM_BYTE;
            end
            default: dtype = decode_pkg::DT_VECTOR;
          endcase
        end
        default: dtype = decode_pkg::DT_VECTOR;
      endcase
    end
  end
endmodule

// ===== core/dispatch_decoder.sv
// dispatch decode classifier: pairing, length and unit steering
`include "decode_consts.svh"
module dispatch_decoder #(
  parameter int SLOTS = 2,  // decode slots per clock
  parameter int OPS   = 3   // operations per instruction
) (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic [1:0]                 in_valid,
  input  wire logic [1:0][7:0]            in_opcode,
  input  wire logic [1:0][7:0]            in_second,
  input  wire logic [1:0][7:0]            in_third,
  input  wire logic                       op_size32,
  input  wire logic                       addr_size32,
  input  wire logic                       sched_ready,
  output logic [1:0]                      advance_r,
  output logic [1:0]                      dec_valid_r,
  output logic [1:0][1:0]                 dec_type_r,
  output logic [1:0][2:0][3:0]            op_kind_r,
  output logic [1:0][2:0][2:0]            op_unit_r,
  output logic [1:0][2:0]                 op_chain_r,
  output logic [1:0][2:0]                 reg_operand_r,
  output logic [1:0][2:0]                 rm_operand_r,
  output logic [1:0]                      mem_form_r,
  output logic [1:0]                      vector_form_r,
  output logic [1:0][3:0]                 length_r
);

  // per-slot classification from the slot decoders; s_len comes from instr_len here
  decode_pkg::dtype_type              s_dtype   [2];
  decode_pkg::op_kind_type [2:0]      s_kind    [2];
  logic [2:0]                         s_chain   [2];
  logic                               s_modrm_u [2];  // modrm present
  logic                               s_esc     [2];  // two-byte opcode
  logic                               s_mem     [2];  // memory form
  logic                               s_vec     [2];  // vector registers
  logic [7:0]                         s_modrm   [2];  // selected modrm
  decode_pkg::imm_size_type           s_imm     [2];
  logic [2:0]                         s_reg     [2];
  logic [2:0]                         s_rm      [2];
  logic [3:0]                         s_len     [2];  // instruction bytes

  // group selection
  logic                               take0;    // first slot decodes
  logic                               pair;     // both slots decode
  logic                               load_grp; // outputs may change

  // next values of the output group
  logic [1:0]                         advance_nxt;
  logic [1:0]                         dec_valid_nxt;
  logic [1:0][1:0]                    dec_type_nxt;
  logic [1:0][2:0][3:0]               op_kind_nxt;
  logic [1:0][2:0][2:0]               op_unit_nxt;
  logic [1:0][2:0]                    op_chain_nxt;
  logic [1:0][2:0]                    reg_operand_nxt;
  logic [1:0][2:0]                    rm_operand_nxt;
  logic [1:0]                         mem_form_nxt;
  logic [1:0]                         vector_form_nxt;
  logic [1:0][3:0]                    length_nxt;

  // alternation between the two integer units
  logic                               steer_y_r;
  logic                               steer_y_nxt;

  // length of one instruction from its fields
  function automatic logic [3:0] instr_len(
    input logic                     esc,
    input logic                     hm,
    input logic [7:0]               m,
    input decode_pkg::imm_size_type imm,
    input logic                     o32,
    input logic                     a32
  );
    logic [3:0] n;
    logic [3:0] full_o;
    logic [3:0] full_a;
    logic [1:0] md;
    logic [2:0] rm;
    full_o = o32 ? `LEN_FULL_32 : `LEN_FULL_16;
    full_a = a32 ? `LEN_FULL_32 : `LEN_FULL_16;
    md     = m[`MODRM_MOD_HI:`MODRM_MOD_LO];
    rm     = m[`MODRM_RM_HI:`MODRM_RM_LO];
    n      = esc ? 4'h2 : 4'h1;
    if (hm) begin
      n = n + 4'h1;
      // index byte only exists with 32-bit addressing
      if (a32 && md != `MOD_REG_FORM && rm == `RM_SIB)
        n = n + 4'h1;
      unique case (md)
        `MOD_DISP8:     n = n + 4'h1; // short displacement
        `MOD_DISP_FULL: n = n + full_a;
        `MOD_NO_DISP: begin
          // direct address carries a full displacement
          if (a32 ? (rm == `RM_DISP_ONLY_32) : (rm == `RM_DISP_ONLY_16))
            n = n + full_a;
        end
        `MOD_REG_FORM:  n = n + 4'h0;
      endcase
    end
    unique case (imm)
      decode_pkg::IMM_BYTE: n = n + 4'h1;
      decode_pkg::IMM_FULL: n = n + full_o;
      default:              n = n + 4'h0;
    endcase
    return n;
  endfunction

  // target unit of one operation; alu takes the offered unit
  function automatic decode_pkg::unit_type kind_unit(
    input decode_pkg::op_kind_type k,
    input logic                    use_y
  );
    unique case (k)
      decode_pkg::OP_LOAD,
      decode_pkg::OP_FLOAD,
      decode_pkg::OP_MLOAD:  return decode_pkg::UNIT_LOAD;
      decode_pkg::OP_STORE:  return decode_pkg::UNIT_STORE;
      decode_pkg::OP_ALU:    return use_y ? decode_pkg::UNIT_INT_Y
                                          : decode_pkg::UNIT_INT_X;
      decode_pkg::OP_ALUX:   return decode_pkg::UNIT_INT_X;
      decode_pkg::OP_BRANCH: return decode_pkg::UNIT_BRANCH;
      decode_pkg::OP_FLOAT:  return decode_pkg::UNIT_FPU;
      decode_pkg::OP_MEU:    return decode_pkg::UNIT_MEU;
      default:               return decode_pkg::UNIT_NONE;
    endcase
  endfunction

  // one classifier per decode slot
  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    decode_slot u_slot (
      .valid       (in_valid[g]),
      .opcode      (in_opcode[g]),
      .second      (in_second[g]),
      .third       (in_third[g]),
      .dtype       (s_dtype[g]),
      .op_kind     (s_kind[g]),
      .op_chain    (s_chain[g]),
      .has_modrm   (s_modrm_u[g]),
      .escaped     (s_esc[g]),
      .mem_form    (s_mem[g]),
      .vector_form (s_vec[g]),
      .modrm       (s_modrm[g]),
      .imm_size    (s_imm[g]),
      .reg_operand (s_reg[g]),
      .rm_operand  (s_rm[g])
    );
    assign s_len[g] = instr_len(s_esc[g], s_modrm_u[g], s_modrm[g],
                                s_imm[g], op_size32, addr_size32);
  end

  // decide how much of the window decodes this clock
  always_comb begin
    // a held group must be taken by the scheduler before a new one
    load_grp = sched_ready | ~(|dec_valid_r);
    take0    = load_grp & in_valid[0];
    // only two short instructions share a clock, of any class
    pair     = take0 & in_valid[1] &
               (s_dtype[0] == decode_pkg::DT_SHORT) &
               (s_dtype[1] == decode_pkg::DT_SHORT);
    // long and vector decodes go alone
    advance_nxt = pair ? 2'd2 : (take0 ? 2'd1 : 2'd0);
  end

  // build the next output group and steer its operations
  always_comb begin
    logic use_y;
    logic live;
    use_y           = steer_y_r;
    live            = 1'b0;
    dec_valid_nxt   = dec_valid_r;
    dec_type_nxt    = dec_type_r;
    op_kind_nxt     = op_kind_r;
    op_unit_nxt     = op_unit_r;
    op_chain_nxt    = op_chain_r;
    reg_operand_nxt = reg_operand_r;
    rm_operand_nxt  = rm_operand_r;
    mem_form_nxt    = mem_form_r;
    vector_form_nxt = vector_form_r;
    length_nxt      = length_r;
    if (load_grp) begin
      for (int s = 0; s < SLOTS; s++) begin
        live = (s == 0) ? take0 : pair;
        dec_valid_nxt[s]   = live;
        dec_type_nxt[s]    = live ? s_dtype[s] : decode_pkg::DT_NONE;
        reg_operand_nxt[s] = s_reg[s];
        rm_operand_nxt[s]  = s_rm[s];
        mem_form_nxt[s]    = live & s_mem[s];
        vector_form_nxt[s] = live & s_vec[s];
        length_nxt[s]      = live ? s_len[s] : 4'h0;
        op_chain_nxt[s]    = live ? s_chain[s] : 3'h0;
        for (int o = 0; o < OPS; o++) begin
          op_kind_nxt[s][o] = live ? s_kind[s][o] : decode_pkg::OP_NONE;
          op_unit_nxt[s][o] = live ? kind_unit(s_kind[s][o], use_y)
                                   : decode_pkg::UNIT_NONE;
          // unrestricted ops alternate so both units stay busy
          if (live && s_kind[s][o] == decode_pkg::OP_ALU)
            use_y = ~use_y;
        end
      end
    end
    steer_y_nxt = use_y;
  end

  // register the group; hold while the scheduler stalls
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      advance_r     <= '0;
      dec_valid_r   <= '0;
      dec_type_r    <= '0;
      op_kind_r     <= '0;
      op_unit_r     <= '0;
      op_chain_r    <= '0;
      reg_operand_r <= '0;
      rm_operand_r  <= '0;
      mem_form_r    <= '0;
      vector_form_r <= '0;
      length_r      <= '0;
      steer_y_r     <= `STEER_RESET;
    end else begin
      advance_r     <= advance_nxt;
      dec_valid_r   <= dec_valid_nxt;
      dec_type_r    <= dec_type_nxt;
      op_kind_r     <= op_kind_nxt;
      op_unit_r     <= op_unit_nxt;
      op_chain_r    <= op_chain_nxt;
      reg_operand_r <= reg_operand_nxt;
      rm_operand_r  <= rm_operand_nxt;
      mem_form_r    <= mem_form_nxt;
      vector_form_r <= vector_form_nxt;
      length_r      <= length_nxt;
      steer_y_r     <= steer_y_nxt;
    end
  end

endmodule
